/* File: design/bmc_basic_mode_control.v */
`timescale 1ns/100ps
`include "bmc_map.vh"
// ----------------------------------------
// Overview of operation
// - writing one to the reset bit starts a device reset, reads one until done, then clears and reloads straps.
// - loopback set routes mac transmit data back onto mac receive data.
// - after loopback is enabled receive data may stay invalid for about 500 us of dead time.
// - with auto-negotiation off, speed select one gives 100 Mb/s and zero gives 10 Mb/s.
// - auto-negotiation enable and speed select take their reset values from strap inputs.
// - fiber mode forces the auto-negotiation enable bit to zero.
// - with auto-negotiation on, speed and duplex bits are ignored; off, they set speed and duplex.
// - the power-down bit powers down the transceiver while register access keeps working.
// - power down is the or of the bit and the active-low pin, and the pin sets the bit.
// - isolate disconnects the port from the mac interface while management stays live.
// - clear-on-read fields are read-only and a read clears them after returning the value.
// - latched-low fields hold a low event until read, then follow the live condition.
// - latched-high fields hold a high event until read, then follow the live condition.
// - self-clearing fields set on their event and return to zero when it ends.
// - permanent read-only fields always return their fixed value and ignore writes.
// ----------------------------------------
module bmc_basic_mode_control #(
  parameter DEAD_CYC = `BMC_DEAD_CYC,
  parameter SRST_CYC = `BMC_SRST_CYC
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // avalon-mm slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // straps and pins
  input wire strap_aneg_i,
  input wire strap_speed_i,
  input wire strap_duplex_i,
  input wire fiber_mode_select_i,
  input wire power_down_input_pin_n_i,
  // access-type event sources
  input wire [7:0] cor_event_i,
  input wire ll_cond_i,
  input wire lh_cond_i,
  input wire sc_event_i,
  // mac-side data path
  input wire [3:0] mac_txd_i,
  input wire mac_tx_en_i,
  input wire [3:0] line_rxd_i,
  input wire line_rx_dv_i,
  output reg [3:0] mac_rxd_o,
  output reg mac_rx_dv_o,
  output reg [3:0] line_txd_o,
  output reg line_tx_en_o,
  // port state
  output reg rate_100_o,
  output reg full_duplex_o,
  output reg aneg_active_o,
  output reg power_down_o,
  output reg isolate_o,
  output reg soft_reset_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [8:0] sync_q;
  bmc_sync #(
    .W(9)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({~power_down_input_pin_n_i, fiber_mode_select_i, strap_duplex_i, strap_speed_i, strap_aneg_i,
          ll_cond_i, lh_cond_i, sc_event_i, 1'b0}),
    .q_o(sync_q)
  );
  wire pin_pdown = sync_q[8];
  wire fiber = sync_q[7];
  wire s_duplex = sync_q[6];
  wire s_speed = sync_q[5];
  wire s_aneg = sync_q[4];
  wire ll_live = sync_q[3];
  wire lh_live = sync_q[2];
  wire sc_live = sync_q[1];

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // one wait cycle so read data come from a register
  reg ack;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  wire wr = avs_write_i & ack;
  wire rd_done = avs_read_i & ack;
  wire wr_ctrl = wr & (avs_address_i == `BMC_CTRL_ADDR);
  wire rd_at = rd_done & (avs_address_i == `BMC_ATYPE_ADDR);

  // ----------------------------------------
  // reset sequencer
  // ----------------------------------------
  // straps need two clocks through the synchroniser before they are caught
  localparam [2:0] SEQ_BOOT0 = 3'h0;
  localparam [2:0] SEQ_BOOT1 = 3'h1;
  localparam [2:0] SEQ_BOOT_LOAD = 3'h2;
  localparam [2:0] SEQ_RUN = 3'h3;
  localparam [2:0] SEQ_BUSY = 3'h4;
  localparam [2:0] SEQ_SRST_LOAD = 3'h5;
  reg [2:0] seq_state;
  reg [2:0] next_seq_state;
  reg [7:0] srst_cnt;
  wire srst = (seq_state == SEQ_BUSY) | (seq_state == SEQ_SRST_LOAD);
  wire strap_load = (seq_state == SEQ_BOOT_LOAD) | (seq_state == SEQ_SRST_LOAD);
  wire srst_req = wr_ctrl & avs_writedata_i[`BMC_RESET_BIT];
  wire sync_ok = (seq_state != SEQ_BOOT0) & (seq_state != SEQ_BOOT1);
  always @* begin
    next_seq_state = seq_state;
    case (seq_state)
      SEQ_BOOT0: begin
        next_seq_state = SEQ_BOOT1;
      end
      SEQ_BOOT1: begin
        next_seq_state = SEQ_BOOT_LOAD;
      end
      SEQ_BOOT_LOAD: begin
        next_seq_state = SEQ_RUN;
      end
      SEQ_RUN: begin
        if (srst_req) begin
          next_seq_state = SEQ_BUSY;
        end
      end
      SEQ_BUSY: begin
        if (srst_cnt == SRST_CYC[7:0] - 8'h01) begin
          next_seq_state = SEQ_SRST_LOAD;
        end
      end
      SEQ_SRST_LOAD: begin
        // reset bit stays set until the straps are back
        next_seq_state = SEQ_RUN;
      end
      default: begin
        next_seq_state = SEQ_BOOT0;
      end
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_state <= SEQ_BOOT0;
      srst_cnt <= 8'h00;
    end else begin
      seq_state <= next_seq_state;
      if (seq_state == SEQ_BUSY) begin
        srst_cnt <= srst_cnt + 8'h01;
      end else begin
        srst_cnt <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  reg loopback;
  reg speed;
  reg aneg;
  reg pdown;
  reg isolate;
  reg duplex;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loopback <= 1'b0;
      speed <= 1'b0;
      aneg <= 1'b0;
      pdown <= 1'b0;
      isolate <= 1'b0;
      duplex <= 1'b0;
    end else begin
      if (strap_load) begin
        loopback <= 1'b0;
        pdown <= 1'b0;
        isolate <= 1'b0;
        speed <= s_speed;
        aneg <= s_aneg;
        duplex <= s_duplex;
      end else if (wr_ctrl & ~srst) begin
        // register writes are held off while the reset runs
        loopback <= avs_writedata_i[`BMC_LOOP_BIT];
        speed <= avs_writedata_i[`BMC_SPEED_BIT];
        aneg <= avs_writedata_i[`BMC_ANEG_BIT];
        pdown <= avs_writedata_i[`BMC_PDOWN_BIT];
        isolate <= avs_writedata_i[`BMC_ISO_BIT];
        duplex <= avs_writedata_i[`BMC_DUPLEX_BIT];
      end
      if (fiber) begin
        aneg <= 1'b0;
      end
      if (pin_pdown) begin
        pdown <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // loopback dead time
  // ----------------------------------------
  reg [15:0] dead_cnt;
  reg loop_q;
  // dead from the very first loopback cycle, no stray valid
  wire loop_rise = loopback & ~loop_q;
  wire dead = (dead_cnt != 16'h0000) | loop_rise;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dead_cnt <= 16'h0000;
      loop_q <= 1'b0;
    end else begin
      loop_q <= loopback;
      if (loop_rise) begin
        dead_cnt <= DEAD_CYC[15:0];
      end else if (dead) begin
        dead_cnt <= dead_cnt - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // port state and data path
  // ----------------------------------------
  wire pd_eff = pdown | pin_pdown;
  wire path_off = pd_eff | isolate | srst;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_100_o <= 1'b0;
      full_duplex_o <= 1'b0;
      aneg_active_o <= 1'b0;
      power_down_o <= 1'b0;
      isolate_o <= 1'b0;
      soft_reset_o <= 1'b0;
      mac_rxd_o <= 4'h0;
      mac_rx_dv_o <= 1'b0;
      line_txd_o <= 4'h0;
      line_tx_en_o <= 1'b0;
    end else begin
      aneg_active_o <= aneg;
      // negotiated results come from elsewhere; forced values apply only with aneg off
      if (!aneg) begin
        rate_100_o <= speed;
        full_duplex_o <= duplex;
      end
      power_down_o <= pd_eff;
      isolate_o <= isolate;
      soft_reset_o <= srst;
      if (path_off) begin
        mac_rxd_o <= 4'h0;
        mac_rx_dv_o <= 1'b0;
        line_txd_o <= 4'h0;
        line_tx_en_o <= 1'b0;
      end else if (loopback) begin
        mac_rxd_o <= mac_txd_i;
        mac_rx_dv_o <= mac_tx_en_i & ~dead;
        line_txd_o <= 4'h0;
        line_tx_en_o <= 1'b0;
      end else begin
        mac_rxd_o <= line_rxd_i;
        mac_rx_dv_o <= line_rx_dv_i;
        line_txd_o <= mac_txd_i;
        line_tx_en_o <= mac_tx_en_i;
      end
    end
  end

  // ----------------------------------------
  // access-type register
  // ----------------------------------------
  reg [7:0] cor;
  reg ll;
  reg lh;
  // new events win over the read clear
  genvar c;
  generate
    for (c = 0; c < 8; c = c + 1) begin : g_cor
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          cor[c] <= 1'b0;
        end else if (cor_event_i[c]) begin
          cor[c] <= 1'b1;
        end else if (rd_at) begin
          cor[c] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ll <= 1'b1;
      lh <= 1'b0;
    end else begin
      // synchroniser output is not valid until boot has passed
      if (!ll_live & sync_ok) begin
        ll <= 1'b0;
      end else if (rd_at) begin
        ll <= 1'b1;
      end
      if (lh_live) begin
        lh <= 1'b1;
      end else if (rd_at) begin
        lh <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  reg [15:0] rd_val;
  always @* begin
    rd_val = 16'h0000;
    case (avs_address_i)
      `BMC_CTRL_ADDR: begin
        rd_val[`BMC_RESET_BIT] = srst;
        rd_val[`BMC_LOOP_BIT] = loopback;
        rd_val[`BMC_SPEED_BIT] = speed;
        rd_val[`BMC_ANEG_BIT] = aneg;
        rd_val[`BMC_PDOWN_BIT] = pdown;
        rd_val[`BMC_ISO_BIT] = isolate;
        rd_val[`BMC_DUPLEX_BIT] = duplex;
      end
      `BMC_STAT_ADDR: begin
        rd_val[`BMC_ST_RATE_BIT] = rate_100_o;
        rd_val[`BMC_ST_DUPLEX_BIT] = full_duplex_o;
        rd_val[`BMC_ST_PDOWN_BIT] = power_down_o;
        rd_val[`BMC_ST_DEAD_BIT] = dead;
        rd_val[`BMC_ST_RSTBUSY_BIT] = srst;
      end
      `BMC_ATYPE_ADDR: begin
        rd_val[`BMC_AT_COR_LSB +: 8] = cor;
        rd_val[`BMC_AT_LL_BIT] = ll;
        rd_val[`BMC_AT_LH_BIT] = lh;
        rd_val[`BMC_AT_SC_BIT] = sc_live;
        rd_val[`BMC_AT_RO_LSB +: 4] = `BMC_AT_RO_VAL;
      end
      default: begin
        rd_val = 16'h0000;
      end
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else begin
      ack <= (avs_read_i | avs_write_i) & ~ack;
      if (avs_read_i & ~ack) begin
        avs_readdata_o <= {16'h0000, rd_val};
      end
    end
  end
endmodule // bmc_basic_mode_control

/* File: design/bmc_map.vh */
`ifndef BMC_MAP_VH
`define BMC_MAP_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define BMC_CTRL_ADDR 4'h0
`define BMC_STAT_ADDR 4'h1
`define BMC_ATYPE_ADDR 4'h2
`define BMC_ADDR_W 4
// ----------------------------------------
// control field positions
// ----------------------------------------
`define BMC_RESET_BIT 15
`define BMC_LOOP_BIT 14
`define BMC_SPEED_BIT 13
`define BMC_ANEG_BIT 12
`define BMC_PDOWN_BIT 11
`define BMC_ISO_BIT 10
`define BMC_DUPLEX_BIT 8
// ----------------------------------------
// status field positions
// ----------------------------------------
`define BMC_ST_RATE_BIT 0
`define BMC_ST_DUPLEX_BIT 1
`define BMC_ST_PDOWN_BIT 2
`define BMC_ST_DEAD_BIT 3
`define BMC_ST_RSTBUSY_BIT 4
// ----------------------------------------
// access-type demo register fields
// ----------------------------------------
`define BMC_AT_COR_LSB 0
`define BMC_AT_LL_BIT 8
`define BMC_AT_LH_BIT 9
`define BMC_AT_SC_BIT 10
`define BMC_AT_RO_LSB 12
`define BMC_AT_RO_VAL 4'ha
// ----------------------------------------
// timing
// ----------------------------------------
`define BMC_CLK_HZ 10000000
`define BMC_DEAD_US 500
`define BMC_DEAD_CYC ((`BMC_DEAD_US * (`BMC_CLK_HZ / 1000000)))
`define BMC_SRST_CYC 16
`endif

/* File: design/bmc_sync.v */
`timescale 1ns/100ps
// two-flop synchroniser, one per bit
module bmc_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // data
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta;
  reg [W-1:0] sync;
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta[g] <= 1'b0;
          sync[g] <= 1'b0;
        end else begin
          meta[g] <= d_i[g];
          sync[g] <= meta[g];
        end
      end
    end
  endgenerate
  assign q_o = sync;
endmodule // bmc_sync

/* File: dv/bmc_asserts.sv */
`timescale 1ns/100ps
// ----
// port checker
// ----
module bmc_asserts #(
  parameter DEAD_CYC = 5000,
  parameter SRST_CYC = 16
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire fiber_mode_select_i,
  input wire power_down_input_pin_n_i,
  input wire mac_rx_dv_o,
  input wire rate_100_o,
  input wire full_duplex_o,
  input wire aneg_active_o,
  input wire power_down_o,
  input wire isolate_o,
  input wire soft_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // counts busy cycles; 8 bits is plenty for the short reset
  reg [7:0] busy_len;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) busy_len <= 8'h00;
    else if (soft_reset_o) busy_len <= busy_len + 8'h01;
    else busy_len <= 8'h00;
  end
  property p_wait; $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
  a_wait: assert property (p_wait) else $error("wait state not one cycle");
  property p_pin; $fell(power_down_input_pin_n_i) |-> ##[1:5] power_down_o; endproperty
  a_pin: assert property (p_pin) else $error("pin did not power down");
  property p_fiber; fiber_mode_select_i [*5] |-> !aneg_active_o; endproperty
  a_fiber: assert property (p_fiber) else $error("aneg on in fiber mode");
  property p_iso; isolate_o && $past(isolate_o) |-> !mac_rx_dv_o; endproperty
  a_iso: assert property (p_iso) else $error("receive valid while isolated");
  property p_hold; aneg_active_o && $past(aneg_active_o) |-> $stable(rate_100_o) && $stable(full_duplex_o); endproperty
  a_hold: assert property (p_hold) else $error("rate moved under aneg");
  property p_blen; $fell(soft_reset_o) |-> busy_len >= SRST_CYC && busy_len <= SRST_CYC + 2; endproperty
  a_blen: assert property (p_blen) else $error("reset busy length wrong");
  property p_bclr; $fell(soft_reset_o) |-> ##[0:2] !isolate_o; endproperty
  a_bclr: assert property (p_bclr) else $error("isolate kept after reset");
  property p_ro; avs_read_i && !avs_waitrequest_o && avs_address_i == 4'h2 |-> avs_readdata_o[15:12] == 4'ha;
  endproperty
  a_ro: assert property (p_ro) else $error("fixed field wrong");
  c_srst: cover property ($fell(soft_reset_o));
  c_pd: cover property ($rose(power_down_o));
  c_iso: cover property (isolate_o && $past(isolate_o));
endmodule // bmc_asserts
bind bmc_basic_mode_control bmc_asserts #(.DEAD_CYC(DEAD_CYC), .SRST_CYC(SRST_CYC)) chk_u (.clk_i, .rst_n_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .fiber_mode_select_i,
  .power_down_input_pin_n_i, .mac_rx_dv_o, .rate_100_o, .full_duplex_o, .aneg_active_o, .power_down_o,
  .isolate_o, .soft_reset_o);

/* File: dv/bmc_mgmt_model.sv */
`timescale 1ns/100ps
// ----
// management controller model
// ----
module bmc_mgmt_model (
  // clock
  input wire clk_i,
  // avalon-mm master
  output reg [3:0] address_o,
  output reg read_o,
  output reg write_o,
  output reg [31:0] writedata_o,
  input wire [31:0] readdata_i,
  input wire waitrequest_i
);
  initial begin
    {address_o, read_o, write_o, writedata_o} = 38'h0;
  end
  // waitrequest and read data taken only at the rising edge
  task automatic xfer(input rw, input [3:0] a, input [15:0] d, output [15:0] q);
    begin
      @(posedge clk_i);
      address_o <= a;
      writedata_o <= {16'h0000, d};
      read_o <= !rw;
      write_o <= rw;
      @(posedge clk_i);
      while (waitrequest_i) begin
        @(posedge clk_i);
      end
      q = readdata_i[15:0];
      read_o <= 1'b0;
      write_o <= 1'b0;
    end
  endtask
  // no set-up until the reset bit has cleared
  task automatic wait_reset(output [15:0] q);
    begin
      q = 16'h8000;
      while (q[15]) xfer(1'b0, 4'h0, 16'h0000, q);
    end
  endtask
endmodule // bmc_mgmt_model

/* File: dv/bmc_basic_mode_control_tb.sv */
`timescale 1ns/100ps
// ----
// testbench
// ----
module bmc_basic_mode_control_tb;
  localparam DEAD = 8;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg strap_aneg_i, strap_speed_i, strap_duplex_i;
  reg fiber_mode_select_i = 1'b0;
  reg power_down_input_pin_n_i = 1'b1;
  reg [7:0] cor_event_i = 8'h00;
  reg ll_cond_i = 1'b1;
  reg lh_cond_i = 1'b0;
  reg sc_event_i = 1'b0;
  reg [3:0] mac_txd_i = 4'h0;
  reg mac_tx_en_i = 1'b0;
  reg [3:0] line_rxd_i = 4'h5;
  reg line_rx_dv_i = 1'b1;
  wire [3:0] avs_address_i, mac_rxd_o, line_txd_o;
  wire [31:0] avs_writedata_i, avs_readdata_o;
  wire avs_read_i, avs_write_i, avs_waitrequest_o, mac_rx_dv_o, line_tx_en_o;
  wire rate_100_o, full_duplex_o, aneg_active_o, power_down_o, isolate_o, soft_reset_o;
  integer seed = 53329;
  integer error_cnt = 0;
  integer n_checks = 0;
  integer i;
  reg [15:0] rd, cw;
  reg [7:0] cv;
  reg [2:0] r;
  reg er, ed;
  always #50 clk_i = ~clk_i;
  bmc_basic_mode_control #(.DEAD_CYC(DEAD)) dut_u (.*);
  bmc_mgmt_model mm_u (.clk_i, .address_o(avs_address_i), .read_o(avs_read_i), .write_o(avs_write_i),
    .writedata_o(avs_writedata_i), .readdata_i(avs_readdata_o), .waitrequest_i(avs_waitrequest_o));
  // f is {speed, aneg, pdown, isolate, loop, duplex}
  function [15:0] ctrl_e(input [5:0] f);
    ctrl_e = {1'b0, f[1], f[5], f[4], f[3], f[2], 1'b0, f[0], 8'h00};
  endfunction
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #500000;
    error_cnt = error_cnt + 1;
    results;
  end
  initial begin
    {strap_speed_i, strap_aneg_i, strap_duplex_i} = $random(seed);
    er = strap_aneg_i ? 1'b0 : strap_speed_i;
    ed = strap_aneg_i ? 1'b0 : strap_duplex_i;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    mm_u.xfer(1'b0, 4'h0, 16'h0, rd);
    chk("ctrl_strap", ctrl_e({strap_speed_i, strap_aneg_i, 3'b000, strap_duplex_i}), rd);
    for (i = 0; i < 6; i = i + 1) begin
      r = $random(seed);
      cw = ctrl_e({r[2], i[0], 1'b0, r[1], 1'b0, r[0]});
      mm_u.xfer(1'b1, 4'h0, cw, rd);
      if (!cw[12]) {er, ed} = {cw[13], cw[8]};
      repeat (3) @(posedge clk_i);
      chk("rate", er, rate_100_o);
      chk("duplex", ed, full_duplex_o);
      chk("isolate", cw[10], isolate_o);
      mm_u.xfer(1'b0, 4'h0, 16'h0, rd);
      chk("ctrl_rb", cw, rd);
    end
    mm_u.xfer(1'b1, 4'h0, 16'h0000, rd);
    repeat (2) @(posedge clk_i);
    chk("rx_normal", 5'h15, {mac_rx_dv_o, mac_rxd_o});
    mm_u.xfer(1'b1, 4'h0, ctrl_e(6'b000010), rd);
    mac_txd_i <= 4'ha;
    mac_tx_en_i <= 1'b1;
    mm_u.xfer(1'b0, 4'h1, 16'h0, rd);
    chk("dead", 1, rd[3]);
    chk("dead_dv", 0, mac_rx_dv_o);
    repeat (DEAD + 4) @(posedge clk_i);
    chk("loop_rx", 5'h1a, {mac_rx_dv_o, mac_rxd_o});
    fiber_mode_select_i <= 1'b1;
    mm_u.xfer(1'b1, 4'h0, ctrl_e(6'b010000), rd);
    repeat (4) @(posedge clk_i);
    mm_u.xfer(1'b0, 4'h0, 16'h0, rd);
    chk("fiber_aneg", 0, rd[12]);
    chk("line_tx", 5'h1a, {line_tx_en_o, line_txd_o});
    fiber_mode_select_i <= 1'b0;
    power_down_input_pin_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    power_down_input_pin_n_i <= 1'b1;
    mm_u.xfer(1'b0, 4'h0, 16'h0, rd);
    chk("pd_bit", 1, rd[11]);
    chk("pd_out", 1, power_down_o);
    chk("pd_rx", 0, mac_rx_dv_o);
    mm_u.xfer(1'b1, 4'h0, 16'h0000, rd);
    repeat (3) @(posedge clk_i);
    chk("pd_clear", 0, power_down_o);
    cv = $random(seed);
    cor_event_i <= cv;
    {ll_cond_i, lh_cond_i, sc_event_i} <= 3'b011;
    @(posedge clk_i);
    cor_event_i <= 8'h00;
    repeat (4) @(posedge clk_i);
    {ll_cond_i, lh_cond_i} <= 2'b10;
    repeat (4) @(posedge clk_i);
    mm_u.xfer(1'b0, 4'h2, 16'h0, rd);
    chk("atype_held", {4'ha, 4'b0110, cv}, rd);
    sc_event_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    mm_u.xfer(1'b0, 4'h2, 16'h0, rd);
    chk("atype_live", 16'ha100, rd);
    mm_u.xfer(1'b1, 4'h2, 16'h0000, rd);
    mm_u.xfer(1'b0, 4'h2, 16'h0, rd);
    chk("atype_fixed", 4'ha, rd[15:12]);
    mm_u.xfer(1'b1, 4'h7, 16'hffff, rd);
    mm_u.xfer(1'b0, 4'h7, 16'h0, rd);
    chk("unmapped", 0, rd);
    {strap_speed_i, strap_aneg_i, strap_duplex_i} <= $random(seed);
    repeat (4) @(posedge clk_i);
    mm_u.xfer(1'b1, 4'h0, ctrl_e(6'b000110) | 16'h8000, rd);
    mm_u.xfer(1'b0, 4'h0, 16'h0, rd);
    chk("rst_busy", 1, rd[15]);
    mm_u.wait_reset(rd);
    chk("rst_reload", ctrl_e({strap_speed_i, strap_aneg_i, 3'b000, strap_duplex_i}), rd);
    results;
  end
endmodule // bmc_basic_mode_control_tb
